//--- logic/pslc_codec.sv
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// R1: management access to phy registers only when target address is 00000.
// R2: phy starts isolated after reset; leaves isolation when isolate bit cleared.
// R3: external phy select resets to 0; clearing it re-enables internal phy.
// R4: while isolated, mii inputs ignored, mii and line outputs high impedance.
// R5: 100 Mbps encoder maps each nibble to its 5-bit code group.
// R6: first two preamble nibbles replaced by J then K.
// R7: after last data nibble, append T then R.
// R8: idle code groups 11111 sent continuously between frames.
// R9: 10 Mbps cell carries complement first half, true data second half.
// R10: start-of-idle pulse appended after last Manchester bit.
// R11: 10 Mbps idle not encoded; link pulses sent instead.
// R12: 100 Mbps decoder maps groups to nibbles; unused groups give 0000.
// R13: received J K replaced by two Data 5 nibbles.
// R14: received T R replaced by two Data 0 nibbles.
// R15: delimiter and codeword errors raise rx_er with the affected nibble.
// R16: each error type sets its own sticky status bit.
// R17: 10 Mbps decoder yields nrz nibbles and drops the start-of-idle pulse.
// R18: 10 Mbps bypasses scrambling, uses Manchester instead of block code.
// R19: transmit path is block encoder, then scrambler, then line.
// R20: receive path is descrambler, then block decoder, then mac.
// R21: nibble bit 0 is least significant and first on the line.
// R22: nibble clocks run at 25 MHz or 2.5 MHz per speed.
// R23: exactly one code group per transmit nibble clock, no gaps.
module pslc_codec #(
   parameter int LINK_PULSE_CYC = pslc_pkg::LINK_PULSE_CYC
) (
   // clock, reset, enable
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // mii transmit side
   input  wire logic        transmit_nibble_clock,
   input  wire logic        tx_en,
   input  wire logic [3:0]  txd,
   // mii receive side
   input  wire logic        receive_nibble_clock,
   output logic      [3:0]  rxd,
   output logic             rx_dv,
   output logic             rx_er,
   output logic             mii_out_oe,
   // line side
   output logic      [4:0]  tx_group,
   output logic             tx_line,
   output logic             tx_line_oe,
   input  wire logic [4:0]  rx_group,
   input  wire logic        rx_line,
   input  wire logic        rx_carrier
);

   typedef struct packed {
      logic                iso;
      logic                ext;
      logic                spd;
      logic                byp;
      logic [4:0]          maddr;
      logic                e_ssd;
      logic                e_esd;
      logic                e_code;
      logic                dp_wr;
      logic [7:0]          dp_addr;
      logic [31:0]         hrdata;
      logic [2:0]          txc;
      logic [2:0]          rxc;
      logic [1:0]          txen;
      logic [7:0]          txd;
      logic [9:0]          rxg;
      logic [1:0]          rxl;
      logic [1:0]          rcar;
      pslc_pkg::pslc_tx_e  tx_st;
      logic [4:0]          tx_group;
      logic [10:0]         scr;
      logic [10:0]         dscr;
      logic                tx_line;
      logic                tx_oe;
      logic [2:0]          mph;
      logic [3:0]          mnib;
      logic                mact;
      logic [1:0]          soi;
      logic [17:0]         lp;
      pslc_pkg::pslc_rx_e  rx_st;
      logic [3:0]          rxd;
      logic                rx_dv;
      logic                rx_er;
      logic                rfr;
      logic                rph;
      logic                rfirst;
      logic [3:0]          rbits;
      logic [1:0]          rcnt;
      logic                rrdy;
      logic [3:0]          rnib;
   } pslc_state_s;

   pslc_state_s st;
   pslc_state_s next_st;

   logic isolated;

   assign isolated   = st.iso | st.ext;
   assign hreadyout  = ce;
   assign hresp      = 1'b0;
   assign hrdata     = st.hrdata;
   assign rxd        = st.rxd;
   assign rx_dv      = st.rx_dv;
   assign rx_er      = st.rx_er;
   assign mii_out_oe = ~isolated; // see R4
   assign tx_group   = st.tx_group;
   assign tx_line    = st.tx_line;
   assign tx_line_oe = st.tx_oe;

   always_comb begin
      logic        acc;
      logic        own;
      logic        txfe;
      logic        rxfe;
      logic        txen_v;
      logic [3:0]  txd_v;
      logic [4:0]  g;
      logic [4:0]  o;
      logic [4:0]  s;
      logic [4:0]  p;
      logic [4:0]  dec;
      logic [10:0] lf;
      logic [10:0] lr;
      logic        key;
      acc    = 1'b0;
      own    = 1'b0;
      txfe   = 1'b0;
      rxfe   = 1'b0;
      txen_v = 1'b0;
      txd_v  = 4'h0;
      g      = pslc_pkg::SYM_I; // see R8
      o      = 5'h00;
      s      = 5'h00;
      p      = 5'h00;
      dec    = 5'h00;
      lf     = 11'h000;
      lr     = 11'h000;
      key    = 1'b0;
      next_st = st;
      if (ce) begin
         next_st.txc  = {st.txc[1:0], transmit_nibble_clock};
         next_st.rxc  = {st.rxc[1:0], receive_nibble_clock};
         next_st.txen = {st.txen[0], tx_en};
         next_st.txd  = {st.txd[3:0], txd};
         next_st.rxg  = {st.rxg[4:0], rx_group};
         next_st.rxl  = {st.rxl[0], rx_line};
         next_st.rcar = {st.rcar[0], rx_carrier};
         txfe   = st.txc[2] & ~st.txc[1]; // see R22
         rxfe   = st.rxc[2] & ~st.rxc[1]; // see R22
         txen_v = st.txen[1] & ~isolated; // see R4
         txd_v  = isolated ? 4'h0 : st.txd[7:4]; // see R4
         own = (st.maddr == pslc_pkg::PHY_ADDR); // see R1
         if (st.dp_wr) begin
            if (st.dp_addr == pslc_pkg::ADDR_MADDR) begin
               next_st.maddr = hwdata[4:0];
            end else if (own && st.dp_addr == pslc_pkg::ADDR_CTRL) begin
               next_st.iso = hwdata[pslc_pkg::CTRL_ISO]; // see R2
               next_st.ext = hwdata[pslc_pkg::CTRL_EXT]; // see R3
               next_st.spd = hwdata[pslc_pkg::CTRL_SPD];
               next_st.byp = hwdata[pslc_pkg::CTRL_BYP];
            end else if (own && st.dp_addr == pslc_pkg::ADDR_STAT) begin
               next_st.e_ssd  = st.e_ssd & ~hwdata[pslc_pkg::STAT_SSD];
               next_st.e_esd  = st.e_esd & ~hwdata[pslc_pkg::STAT_ESD];
               next_st.e_code = st.e_code & ~hwdata[pslc_pkg::STAT_CODE];
            end
         end
         // 100 Mbps transmit: encoder then scrambler
         if (st.spd) begin
            next_st.tx_oe   = ~isolated; // see R4
            next_st.tx_line = 1'b0;
            next_st.mact    = 1'b0;
            next_st.soi     = 2'h0;
            if (txfe) begin
               case (st.tx_st)
                  pslc_pkg::TX_IDLE: begin
                     if (txen_v) begin
                        g = pslc_pkg::SYM_J; // see R6
                        next_st.tx_st = pslc_pkg::TX_SENDK;
                     end
                  end
                  pslc_pkg::TX_SENDK: begin
                     g = pslc_pkg::SYM_K; // see R6
                     next_st.tx_st = pslc_pkg::TX_DATA;
                  end
                  pslc_pkg::TX_DATA: begin
                     if (txen_v) begin
                        g = pslc_pkg::pslc_enc(txd_v); // see R5
                     end else begin
                        g = pslc_pkg::SYM_T; // see R7
                        next_st.tx_st = pslc_pkg::TX_SENDR;
                     end
                  end
                  pslc_pkg::TX_SENDR: begin
                     g = pslc_pkg::SYM_R; // see R7
                     next_st.tx_st = pslc_pkg::TX_IDLE;
                  end
                  default: begin
                     g = pslc_pkg::SYM_I;
                     next_st.tx_st = pslc_pkg::TX_IDLE;
                  end
               endcase
               lf = (st.scr == 11'h000) ? 11'h7ff : st.scr;
               for (int i = 4; i >= 0; i--) begin
                  key  = lf[10] ^ lf[8];
                  o[i] = st.byp ? g[i] : g[i] ^ key; // see R19
                  lf   = {lf[9:0], key};
               end
               next_st.scr      = lf;
               next_st.tx_group = o; // see R23
            end
         end else begin
            // 10 Mbps transmit: manchester, no scrambler
            next_st.tx_st = pslc_pkg::TX_IDLE; // see R18
            next_st.lp    = st.lp + 18'h00001;
            if (st.mact) begin
               next_st.tx_line = st.mnib[st.mph[2:1]] ^ ~st.mph[0]; // see R9
               next_st.tx_oe   = ~isolated; // see R4
               next_st.mph     = st.mph + 3'h1;
            end else if (st.soi != 2'h0) begin
               next_st.tx_line = 1'b1; // see R10
               next_st.tx_oe   = ~isolated; // see R4
               next_st.soi     = st.soi - 2'h1;
            end else if (st.lp >= 18'(LINK_PULSE_CYC - 1)) begin
               next_st.tx_line = 1'b1; // see R11
               next_st.tx_oe   = ~isolated;
               next_st.lp      = 18'h00000;
            end else begin
               next_st.tx_line = 1'b0; // see R11
               next_st.tx_oe   = 1'b0;
            end
            if (txfe) begin
               if (txen_v) begin
                  next_st.mnib = txd_v;
                  next_st.mact = 1'b1;
                  next_st.mph  = 3'h0;
               end else if (st.mact) begin
                  next_st.mact = 1'b0;
                  next_st.soi  = 2'(pslc_pkg::SOI_CYC); // see R10
               end
            end
         end
         // 100 Mbps receive: descrambler then block decoder
         if (st.spd && rxfe) begin
            s  = st.rxg[9:5];
            lf = st.dscr;
            lr = st.dscr;
            for (int i = 4; i >= 0; i--) begin
               key  = lf[10] ^ lf[8];
               p[i] = st.byp ? s[i] : s[i] ^ key; // see R20
               lf   = {lf[9:0], key};
               lr   = {lr[9:0], ~s[i]};
            end
            // out of lock while idle: reload key from the idle stream
            if (st.rx_st == pslc_pkg::RX_IDLE && !st.byp &&
                p != pslc_pkg::SYM_I && p != pslc_pkg::SYM_J) begin
               next_st.dscr = lr;
               p = pslc_pkg::SYM_I;
            end else begin
               next_st.dscr = lf;
            end
            next_st.rxd   = pslc_pkg::NIB_DATA0;
            next_st.rx_dv = 1'b0;
            next_st.rx_er = 1'b0;
            case (st.rx_st)
               pslc_pkg::RX_IDLE: begin
                  if (p == pslc_pkg::SYM_J) begin
                     next_st.rxd   = pslc_pkg::NIB_DATA5; // see R13
                     next_st.rx_dv = 1'b1;
                     next_st.rx_st = pslc_pkg::RX_WAITK;
                  end else if (p != pslc_pkg::SYM_I) begin
                     next_st.rx_er = 1'b1; // see R15
                     next_st.e_ssd = 1'b1; // see R16
                  end
               end
               pslc_pkg::RX_WAITK: begin
                  if (p == pslc_pkg::SYM_K) begin
                     next_st.rxd   = pslc_pkg::NIB_DATA5; // see R13
                     next_st.rx_dv = 1'b1;
                     next_st.rx_st = pslc_pkg::RX_DATA;
                  end else begin
                     next_st.rx_er = 1'b1; // see R15
                     next_st.e_ssd = 1'b1; // see R16
                     next_st.rx_st = pslc_pkg::RX_IDLE;
                  end
               end
               pslc_pkg::RX_DATA: begin
                  if (p == pslc_pkg::SYM_T) begin
                     next_st.rx_dv = 1'b1; // see R14
                     next_st.rx_st = pslc_pkg::RX_WAITR;
                  end else if (p == pslc_pkg::SYM_I) begin
                     next_st.rx_er = 1'b1; // see R15
                     next_st.e_esd = 1'b1; // see R16
                     next_st.rx_st = pslc_pkg::RX_IDLE;
                  end else begin
                     dec = pslc_pkg::pslc_dec(p); // see R12
                     next_st.rxd   = dec[3:0];
                     next_st.rx_dv = 1'b1;
                     if (!dec[4]) begin
                        next_st.rx_er  = 1'b1; // see R15
                        next_st.e_code = 1'b1; // see R16
                     end
                  end
               end
               pslc_pkg::RX_WAITR: begin
                  next_st.rx_dv = 1'b1; // see R14
                  next_st.rx_st = pslc_pkg::RX_IDLE;
                  if (p != pslc_pkg::SYM_R) begin
                     next_st.rx_er = 1'b1; // see R15
                     next_st.e_esd = 1'b1; // see R16
                  end
               end
               default: next_st.rx_st = pslc_pkg::RX_IDLE;
            endcase
         end
         // 10 Mbps receive: cells to nrz, start-of-idle dropped
         if (!st.spd) begin
            next_st.rx_st = pslc_pkg::RX_IDLE; // see R18
            if (!st.rfr) begin
               if (st.rcar[1]) begin
                  next_st.rfr  = 1'b1;
                  next_st.rph  = 1'b0;
                  next_st.rcnt = 2'h0;
               end
            end else if (!st.rcar[1]) begin
               next_st.rfr = 1'b0;
            end else if (!st.rph) begin
               next_st.rfirst = st.rxl[1];
               next_st.rph    = 1'b1;
            end else if (st.rfirst == st.rxl[1]) begin
               next_st.rfr = 1'b0; // see R17
            end else begin
               next_st.rph = 1'b0;
               next_st.rbits[st.rcnt] = st.rxl[1]; // see R21
               next_st.rcnt = st.rcnt + 2'h1;
               if (st.rcnt == 2'h3) begin
                  next_st.rnib = {st.rxl[1], st.rbits[2:0]}; // see R17
                  next_st.rrdy = 1'b1;
               end
            end
            if (rxfe) begin
               next_st.rx_er = 1'b0;
               next_st.rx_dv = st.rrdy;
               next_st.rxd   = st.rrdy ? st.rnib : pslc_pkg::NIB_DATA0;
               if (!(next_st.rrdy && !st.rrdy)) begin
                  next_st.rrdy = 1'b0;
               end
            end
         end
         // bus address phase; read data taken after this cycle's writes
         acc = hsel & hready & htrans[1];
         next_st.dp_wr   = acc & hwrite & (haddr[31:8] == 24'h000000);
         next_st.dp_addr = haddr[7:0];
         next_st.hrdata  = 32'h00000000;
         if (acc && !hwrite && haddr[31:8] == 24'h000000) begin
            if (haddr[7:0] == pslc_pkg::ADDR_MADDR) begin
               next_st.hrdata[4:0] = next_st.maddr;
            end else if (next_st.maddr == pslc_pkg::PHY_ADDR) begin // see R1
               if (haddr[7:0] == pslc_pkg::ADDR_CTRL) begin
                  next_st.hrdata[3:0] = {next_st.byp, next_st.spd,
                                         next_st.ext, next_st.iso};
               end else if (haddr[7:0] == pslc_pkg::ADDR_STAT) begin
                  next_st.hrdata[3:0] = {next_st.iso | next_st.ext,
                                         next_st.e_code, next_st.e_esd,
                                         next_st.e_ssd};
               end
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st       <= '0;
         {st.byp, st.spd, st.ext, st.iso} <= pslc_pkg::CTRL_RST; // see R2, R3
         st.tx_st <= pslc_pkg::TX_IDLE;
         st.rx_st <= pslc_pkg::RX_IDLE;
      end else begin
         st <= next_st;
      end
   end

endmodule // pslc_codec

//--- logic/pslc_pkg.sv
package pslc_pkg;

   // timing
   localparam int CLK_NS         = 100;
   localparam int SOI_NS         = 300;
   localparam int SOI_CYC        = (SOI_NS + CLK_NS - 1) / CLK_NS;
   localparam int LINK_PULSE_US  = 16000;
   localparam int LINK_PULSE_CYC = LINK_PULSE_US * 1000 / CLK_NS;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_STAT  = 8'h04;
   localparam logic [7:0] ADDR_MADDR = 8'h08;

   // management address of the internal phy
   localparam logic [4:0] PHY_ADDR   = 5'h00;

   // control field positions and reset value
   localparam int         CTRL_ISO   = 0;
   localparam int         CTRL_EXT   = 1;
   localparam int         CTRL_SPD   = 2;
   localparam int         CTRL_BYP   = 3;
   localparam logic [3:0] CTRL_RST   = 4'h5;

   // status field positions
   localparam int         STAT_SSD   = 0;
   localparam int         STAT_ESD   = 1;
   localparam int         STAT_CODE  = 2;
   localparam int         STAT_ISO   = 3;

   // special code groups and nibbles
   localparam logic [4:0] SYM_I      = 5'h1f;
   localparam logic [4:0] SYM_J      = 5'h18;
   localparam logic [4:0] SYM_K      = 5'h11;
   localparam logic [4:0] SYM_T      = 5'h0d;
   localparam logic [4:0] SYM_R      = 5'h07;
   localparam logic [3:0] NIB_DATA5  = 4'h5;
   localparam logic [3:0] NIB_DATA0  = 4'h0;

   typedef enum logic [3:0] {
      TX_IDLE  = 4'h1,
      TX_SENDK = 4'h2,
      TX_DATA  = 4'h4,
      TX_SENDR = 4'h8
   } pslc_tx_e;

   typedef enum logic [3:0] {
      RX_IDLE  = 4'h1,
      RX_WAITK = 4'h2,
      RX_DATA  = 4'h4,
      RX_WAITR = 4'h8
   } pslc_rx_e;

   // nibble to data code group
   function automatic logic [4:0] pslc_enc(input logic [3:0] n);
      logic [4:0] g;
      g = 5'h1e;
      case (n)
         4'h0: g = 5'h1e;
         4'h1: g = 5'h09;
         4'h2: g = 5'h14;
         4'h3: g = 5'h15;
         4'h4: g = 5'h0a;
         4'h5: g = 5'h0b;
         4'h6: g = 5'h0e;
         4'h7: g = 5'h0f;
         4'h8: g = 5'h12;
         4'h9: g = 5'h13;
         4'ha: g = 5'h16;
         4'hb: g = 5'h17;
         4'hc: g = 5'h1a;
         4'hd: g = 5'h1b;
         4'he: g = 5'h1c;
         default: g = 5'h1d;
      endcase
      return g;
   endfunction

   // data code group to {valid, nibble}; unused groups give 0000
   function automatic logic [4:0] pslc_dec(input logic [4:0] g);
      logic [4:0] d;
      d = 5'h00;
      case (g)
         5'h1e: d = 5'h10;
         5'h09: d = 5'h11;
         5'h14: d = 5'h12;
         5'h15: d = 5'h13;
         5'h0a: d = 5'h14;
         5'h0b: d = 5'h15;
         5'h0e: d = 5'h16;
         5'h0f: d = 5'h17;
         5'h12: d = 5'h18;
         5'h13: d = 5'h19;
         5'h16: d = 5'h1a;
         5'h17: d = 5'h1b;
         5'h1a: d = 5'h1c;
         5'h1b: d = 5'h1d;
         5'h1c: d = 5'h1e;
         5'h1d: d = 5'h1f;
         default: d = 5'h00;
      endcase
      return d;
   endfunction

endpackage

//--- sim/pslc_codec_properties.sv
`timescale 1ns/1ps
module pslc_codec_properties (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus
   input wire logic        ce,
   input wire logic        hsel,
   input wire logic        hready,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // mii and line
   input wire logic        mii_out_oe,
   input wire logic [3:0]  rxd,
   input wire logic        rx_dv,
   input wire logic        rx_er,
   input wire logic [4:0]  tx_group,
   input wire logic        tx_line,
   input wire logic        tx_line_oe
);
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   wire       rd_go  = hsel & hready & htrans[1] & ~hwrite & ce;
   wire [5:0] rx_all = {rx_er, rx_dv, rxd};
   // output held for three more cycles
   sequence held3(v);
      $stable(v) [*3];
   endsequence
   hresp_okay_a: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   ready_ce_a: assert property (hreadyout == ce)
      else $error("hreadyout differs from ce");
   start_iso_a: assert property ($rose(hresetn) |-> !mii_out_oe [*2])
      else $error("phy not isolated after reset");
   line_hiz_a: assert property (!mii_out_oe ##1 !mii_out_oe |-> !tx_line_oe)
      else $error("line driven while isolated");
   read_idle_a: assert property (!rd_go |=> hrdata == 32'h0)
      else $error("read data outside data phase");
   group_stands_a: assert property ($changed(tx_group) && mii_out_oe
      && $past(mii_out_oe) |=> held3(tx_group))
      else $error("code group too short");
   rx_stands_a: assert property ($changed(rx_all) && mii_out_oe
      && $past(mii_out_oe) |=> held3(rx_all))
      else $error("receive nibble too short");
   soi_len_a: assert property ($fell(tx_line_oe) && $past(tx_line)
      && $past(tx_line_oe, 2) |-> $past(tx_line, 2) && $past(tx_line, 3))
      else $error("start of idle pulse too short");
endmodule // pslc_codec_properties

bind pslc_codec pslc_codec_properties chk (
   .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .hready(hready),
   .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .mii_out_oe(mii_out_oe),
   .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .tx_group(tx_group),
   .tx_line(tx_line), .tx_line_oe(tx_line_oe)
);

//--- sim/pslc_mac_model.sv
`timescale 1ns/1ps
module pslc_mac_model (
   // nibble clock, transmit nibbles, line groups
   output logic            nclk,
   output logic            tx_en,
   output logic      [3:0] txd,
   output logic      [4:0] rx_group,
   // observed phy outputs
   input  wire logic       hclk,
   input  wire logic [4:0] tx_group,
   input  wire logic       tx_line,
   input  wire logic       tx_line_oe,
   input  wire logic [3:0] rxd,
   input  wire logic       rx_dv,
   input  wire logic       rx_er
);
   logic [5:0] seen_g[$];
   logic [5:0] seen_r[$];
   logic [5:0] seen_l[$];
   initial begin
      nclk = 1'b0;
      tx_en = 1'b0;
      txd = 4'h0;
      rx_group = 5'h1f;
      #37;
      forever #400 nclk = ~nclk;
   end
   // drive on rising edge, the phy takes on falling
   task automatic send(input logic [3:0] n[$]);
      foreach (n[i]) begin
         @(posedge nclk);
         tx_en <= 1'b1;
         txd   <= n[i];
      end
      @(posedge nclk);
      tx_en <= 1'b0;
      txd   <= ~n[n.size() - 1];
   endtask
   task automatic recv(input logic [4:0] g[$]);
      foreach (g[i]) begin
         @(posedge nclk);
         rx_group <= g[i];
      end
      @(posedge nclk);
      rx_group <= 5'h1f;
   endtask
   always @(negedge nclk) seen_g.push_back({1'b0, tx_group});
   always @(posedge nclk) seen_r.push_back({rx_er, rx_dv, rxd});
   always @(posedge hclk) begin
      if (tx_line_oe) seen_l.push_back({5'h0, tx_line});
   end
endmodule // pslc_mac_model

//--- sim/pslc_codec_bench.sv
`timescale 1ns/1ps
module pslc_codec_bench;
   logic        hclk;
   logic        hresetn;
   logic        ce;
   logic        hready;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        nclk;
   logic        tx_en;
   logic [3:0]  txd;
   logic [3:0]  rxd;
   logic        rx_dv;
   logic        rx_er;
   logic        mii_out_oe;
   logic [4:0]  tx_group;
   logic        tx_line;
   logic        tx_line_oe;
   logic [4:0]  rx_group;
   int          fails;
   int          check_count;
   logic [5:0]  exp_q[$];
   logic [3:0]  nib[$];
   assign hready = hreadyout;
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   pslc_codec #(.LINK_PULSE_CYC(50)) dut (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .transmit_nibble_clock(nclk), .tx_en(tx_en), .txd(txd),
      .receive_nibble_clock(nclk), .rxd(rxd), .rx_dv(rx_dv),
      .rx_er(rx_er), .mii_out_oe(mii_out_oe), .tx_group(tx_group),
      .tx_line(tx_line), .tx_line_oe(tx_line_oe), .rx_group(rx_group),
      .rx_line(1'b0), .rx_carrier(1'b0)
   );
   pslc_mac_model mac (
      .nclk(nclk), .tx_en(tx_en), .txd(txd), .rx_group(rx_group),
      .hclk(hclk), .tx_group(tx_group), .tx_line(tx_line),
      .tx_line_oe(tx_line_oe), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er)
   );
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0, x);
      check(what, x, exp);
   endtask
   // find exp_q as a run inside got, then compare element by element
   task automatic expect_seq(input string what, input logic [5:0] got[$]);
      int k;
      int hit;
      k = 0;
      hit = 0;
      while (!hit && k + exp_q.size() <= got.size()) begin
         hit = 1;
         foreach (exp_q[i]) if (got[k + i] !== exp_q[i]) hit = 0;
         if (!hit) k++;
      end
      if (!hit) k = 0;
      foreach (exp_q[i]) check(what, {26'h0, got[k + i]}, {26'h0, exp_q[i]});
   endtask
   task automatic print_verdict();
      if (fails == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      fails++;
      print_verdict();
   end
   initial begin
      hresetn = 1'b0;
      ce = 1'b1;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk("ctrl reset", pslc_pkg::ADDR_CTRL, 32'h5);
      rd_chk("stat reset", pslc_pkg::ADDR_STAT, 32'h8);
      check("mii oe reset", {31'h0, mii_out_oe}, 32'h0);
      rd_chk("unmapped", 8'h10, 32'h0);
      wr(pslc_pkg::ADDR_MADDR, 32'h1);
      rd_chk("other address", pslc_pkg::ADDR_CTRL, 32'h0);
      wr(pslc_pkg::ADDR_MADDR, 32'h0);
      wr(pslc_pkg::ADDR_CTRL, 32'he);
      rd_chk("ext select", pslc_pkg::ADDR_STAT, 32'h8);
      wr(pslc_pkg::ADDR_CTRL, 32'hc);
      @(negedge hclk);
      check("mii oe on", {31'h0, mii_out_oe}, 32'h1);
      mac.seen_g.delete();
      mac.send('{4'h5, 4'h5, 4'h0, 4'hf, 4'ha});
      repeat (4) @(posedge nclk);
      exp_q = '{6'h18, 6'h11, 6'h1e, 6'h1d, 6'h16, 6'h0d, 6'h07, 6'h1f};
      expect_seq("tx groups", mac.seen_g);
      mac.seen_r.delete();
      mac.recv('{5'h18, 5'h11, 5'h15, 5'h00, 5'h0d, 5'h07});
      repeat (4) @(posedge nclk);
      exp_q = '{6'h15, 6'h15, 6'h13, 6'h30, 6'h10, 6'h10, 6'h00};
      expect_seq("rx nibbles", mac.seen_r);
      rd_chk("code error", pslc_pkg::ADDR_STAT, 32'h4);
      wr(pslc_pkg::ADDR_STAT, 32'h4);
      rd_chk("error cleared", pslc_pkg::ADDR_STAT, 32'h0);
      ce <= 1'b0;
      mac.recv('{5'h00});
      ce <= 1'b1;
      rd_chk("frozen", pslc_pkg::ADDR_STAT, 32'h0);
      wr(pslc_pkg::ADDR_CTRL, 32'h0);
      repeat (2) @(posedge nclk);
      mac.seen_l.delete();
      nib = '{4'h6, 4'h9};
      mac.send(nib);
      repeat (3) @(posedge nclk);
      exp_q.delete();
      foreach (nib[i]) for (int b = 0; b < 4; b++) begin
         exp_q.push_back({5'h0, ~nib[i][b]});
         exp_q.push_back({5'h0, nib[i][b]});
      end
      repeat (pslc_pkg::SOI_CYC) exp_q.push_back(6'h01);
      expect_seq("line cells", mac.seen_l);
      mac.seen_l.delete();
      repeat (150) @(posedge hclk);
      check("link pulses", {31'h0, mac.seen_l.size() inside {[2:4]}}, 32'h1);
      wr(pslc_pkg::ADDR_CTRL, 32'h1);
      repeat (2) @(negedge hclk);
      check("line oe iso", {31'h0, tx_line_oe}, 32'h0);
      check("mii oe iso", {31'h0, mii_out_oe}, 32'h0);
      print_verdict();
   end
endmodule // pslc_codec_bench
